/* hdl/timer_irq_pkg.sv */
// constants, register map and carrier types of the timer and interrupt unit
// assumes one 250 MHz clock; oscillators and port pins arrive as raw levels
package timer_irq_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned N_SRC  = 5;
  localparam int unsigned N_PIN  = 16;
  localparam int unsigned N_IN   = 18;

  localparam logic [7:0] OFS_RELOAD1 = 8'h00;
  localparam logic [7:0] OFS_RELOAD2 = 8'h04;
  localparam logic [7:0] OFS_COUNT1  = 8'h08;
  localparam logic [7:0] OFS_COUNT2  = 8'h0C;
  localparam logic [7:0] OFS_REQ     = 8'h10;
  localparam logic [7:0] OFS_CLR     = 8'h14;
  localparam logic [7:0] OFS_MASK    = 8'h18;
  localparam logic [7:0] OFS_OUT     = 8'h1C;
  localparam logic [7:0] OFS_MODE    = 8'h20;
  localparam logic [7:0] OFS_PINS    = 8'h24;
  localparam logic [7:0] OFS_CTRL    = 8'h28;

  // request bit positions
  localparam int unsigned SRC_PORT = 0;
  localparam int unsigned SRC_T1   = 1;
  localparam int unsigned SRC_RSV  = 3;
  localparam int unsigned SRC_PWM  = 4;
  // synchroniser bit positions of the oscillators
  localparam int unsigned IN_FAST  = 16;

  // control register fields
  localparam int unsigned CTRL_TMR = 0;
  localparam int unsigned CTRL_PD  = 2;

  // two mode bits per pin
  localparam logic [1:0] MODE_NOPULL = 2'h0;
  localparam logic [1:0] MODE_WEAK   = 2'h1;
  localparam logic [1:0] MODE_STRONG = 2'h2;
  localparam logic [1:0] MODE_OUT    = 2'h3;

  localparam logic [7:0]  CNT_MAX     = 8'hFF;
  localparam logic [7:0]  RST_RELOAD  = 8'h00;
  localparam logic [1:0]  RST_TMR_EN  = 2'h3;
  localparam logic [4:0]  RST_MASK    = 5'h00;
  localparam logic [31:0] RST_MODE    = 32'h0000_0000;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [7:0] drv;
    logic [7:0] oe;
    logic [7:0] weak_pu;
    logic [7:0] strong_pu;
  } pin_drive_s;

  typedef struct packed {
    logic [N_IN-1:0]  s1;
    logic [N_IN-1:0]  s2;
    logic [N_IN-1:0]  s3;
    logic [N_IN-1:0]  filt;
    logic [1:0][7:0]  reload;
    logic [1:0][7:0]  cnt;
    logic [1:0]       tmr_en;
    logic [N_SRC-1:0] req;
    logic [N_SRC-1:0] mask;
    logic [N_PIN-1:0] out;
    logic [31:0]      mode;
    logic             pd;
    logic             irq;
    apb_rsp_s         rsp;
    pin_drive_s       p0;
    pin_drive_s       p1;
  } state_s;
endpackage : timer_irq_pkg

/* hdl/timer_irq_unit.sv */
// two reloadable 8-bit timers, five-source interrupt unit and two 8-pin ports
// assumes an APB master on sys_clk; pins and oscillators are asynchronous
`timescale 1ns/1ps
`default_nettype none

module timer_irq_unit (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire timer_irq_pkg::apb_req_s apb_req,
  output var  timer_irq_pkg::apb_rsp_s apb_rsp,
  input  wire logic                    fast_osc_input,
  input  wire logic                    slow_osc_input,
  input  wire logic [7:0]              first_port_pins_lvl,
  input  wire logic [7:0]              second_port_pins_lvl,
  output var  timer_irq_pkg::pin_drive_s first_port_pins_ctl,
  output var  timer_irq_pkg::pin_drive_s second_port_pins_ctl,
  input  wire logic                    pwm_period_end,
  input  wire logic                    reserved_event,
  output logic                         irq,
  output logic                         power_down_indicator
);

  timer_irq_pkg::state_s q;
  timer_irq_pkg::state_s d;

  logic [timer_irq_pkg::N_IN-1:0]  agree;
  logic [timer_irq_pkg::N_IN-1:0]  rise;
  logic [1:0]                      tick;
  logic [timer_irq_pkg::N_SRC-1:0] ev;
  logic [timer_irq_pkg::N_SRC-1:0] clr;
  logic                            wake;
  logic                            acc;
  logic                            wr_take;
  logic [1:0]                      pm;
  logic                            rd_first;

  always_comb begin
    d       = q;
    clr     = '0;
    ev      = '0;
    pm      = '0;
    acc     = apb_req.psel & apb_req.penable;
    // writes land on the edge where the master sees pready
    wr_take = acc & q.rsp.pready & apb_req.pwrite;
    // first access cycle of a read: the answer is loaded from the registers seen here
    rd_first = acc & ~q.rsp.pready & ~apb_req.pwrite;

    // three-stage synchronisers; a level is accepted once stages two and three agree
    d.s1    = {slow_osc_input, fast_osc_input, second_port_pins_lvl, first_port_pins_lvl};
    d.s2    = q.s1;
    d.s3    = q.s2;
    agree   = ~(q.s2 ^ q.s3);
    d.filt  = (q.filt & ~agree) | (q.s2 & agree);
    rise    = d.filt & ~q.filt;

    tick    = rise[timer_irq_pkg::IN_FAST +: 2] & q.tmr_en;
    for (int t = 0; t < 2; t++) begin
      if (tick[t]) begin
        if (q.cnt[t] == timer_irq_pkg::CNT_MAX) begin
          d.cnt[t]                     = q.reload[t];
          ev[timer_irq_pkg::SRC_T1 + t] = 1'b1;
        end else begin
          d.cnt[t] = q.cnt[t] + 8'h01;
        end
      end
    end
    ev[timer_irq_pkg::SRC_PORT] = rise[0];
    ev[timer_irq_pkg::SRC_RSV]  = reserved_event;
    ev[timer_irq_pkg::SRC_PWM]  = pwm_period_end;

    if (wr_take) begin
      case (apb_req.paddr)
        timer_irq_pkg::OFS_RELOAD1: d.reload[0] = apb_req.pwdata[7:0];
        timer_irq_pkg::OFS_RELOAD2: d.reload[1] = apb_req.pwdata[7:0];
        timer_irq_pkg::OFS_CLR:     clr = apb_req.pwdata[timer_irq_pkg::N_SRC-1:0];
        timer_irq_pkg::OFS_MASK:    d.mask = apb_req.pwdata[timer_irq_pkg::N_SRC-1:0];
        timer_irq_pkg::OFS_OUT:     d.out = apb_req.pwdata[15:0];
        timer_irq_pkg::OFS_MODE:    d.mode = apb_req.pwdata;
        timer_irq_pkg::OFS_CTRL: begin
          d.tmr_en = apb_req.pwdata[timer_irq_pkg::CTRL_TMR +: 2];
          if (apb_req.pwdata[timer_irq_pkg::CTRL_PD]) begin
            d.pd = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // a wake in the same cycle as the entry request wins, so no edge is slept through
    wake = |(d.filt[15:0] ^ q.filt[15:0]);
    if (wake) begin
      d.pd = 1'b0;
    end

    // set wins over clear
    d.req = (q.req & ~clr) | ev;
    d.irq = |(d.req & d.mask);

    // one wait state: pready rises at the end of the first access cycle, drops one cycle later
    d.rsp = '0;
    if (acc && !q.rsp.pready) begin
      d.rsp.pready = 1'b1;
      case (apb_req.paddr)
        timer_irq_pkg::OFS_RELOAD1: d.rsp.prdata = {24'h00_0000, q.reload[0]};
        timer_irq_pkg::OFS_RELOAD2: d.rsp.prdata = {24'h00_0000, q.reload[1]};
        timer_irq_pkg::OFS_COUNT1:  d.rsp.prdata = {24'h00_0000, q.cnt[0]};
        timer_irq_pkg::OFS_COUNT2:  d.rsp.prdata = {24'h00_0000, q.cnt[1]};
        timer_irq_pkg::OFS_REQ:     d.rsp.prdata = {27'h000_0000, q.req};
        timer_irq_pkg::OFS_CLR:     d.rsp.prdata = 32'h0000_0000;
        timer_irq_pkg::OFS_MASK:    d.rsp.prdata = {27'h000_0000, q.mask};
        timer_irq_pkg::OFS_OUT:     d.rsp.prdata = {16'h0000, q.out};
        timer_irq_pkg::OFS_MODE:    d.rsp.prdata = q.mode;
        timer_irq_pkg::OFS_PINS:    d.rsp.prdata = {16'h0000, q.filt[15:0]};
        timer_irq_pkg::OFS_CTRL:    d.rsp.prdata = {29'h0000_0000, q.pd, q.tmr_en};
        default:                    d.rsp.pslverr = 1'b1;
      endcase
    end

    // pad controls follow the next mode so outputs stay one flop from the pins
    for (int i = 0; i < 8; i++) begin
      pm                    = d.mode[2*i +: 2];
      d.p0.drv[i]           = d.out[i];
      d.p0.oe[i]            = (pm == timer_irq_pkg::MODE_OUT);
      d.p0.weak_pu[i]       = (pm == timer_irq_pkg::MODE_WEAK);
      d.p0.strong_pu[i]     = (pm == timer_irq_pkg::MODE_STRONG);
      pm                    = d.mode[2*(i+8) +: 2];
      d.p1.drv[i]           = d.out[i+8];
      d.p1.oe[i]            = (pm == timer_irq_pkg::MODE_OUT);
      d.p1.weak_pu[i]       = (pm == timer_irq_pkg::MODE_WEAK);
      d.p1.strong_pu[i]     = (pm == timer_irq_pkg::MODE_STRONG);
    end
  end

  // static storage: nothing but srst clears it, a stalled clock just freezes it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q        <= '0;
      q.reload <= {timer_irq_pkg::RST_RELOAD, timer_irq_pkg::RST_RELOAD};
      q.tmr_en <= timer_irq_pkg::RST_TMR_EN;
      q.mask   <= timer_irq_pkg::RST_MASK;
      q.mode   <= timer_irq_pkg::RST_MODE;
    end else begin
      q <= d;
    end
  end

  assign apb_rsp              = q.rsp;
  assign first_port_pins_ctl  = q.p0;
  assign second_port_pins_ctl = q.p1;
  assign irq                  = q.irq;
  assign power_down_indicator = q.pd;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence

  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence

  sequence s_wrap1;
    tick[0] && q.cnt[0] == timer_irq_pkg::CNT_MAX;
  endsequence

  apb_wait_state_a: assert property (s_setup ##1 s_access |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("apb answer not one wait state");

  timer_wrap_a: assert property (s_wrap1 |=> q.cnt[0] == $past(q.reload[0]) && q.req[timer_irq_pkg::SRC_T1])
    else $error("timer one did not reload and request");

  timer_count_a: assert property (tick[1] && q.cnt[1] != timer_irq_pkg::CNT_MAX |=> q.cnt[1] == $past(q.cnt[1]) + 8'h01)
    else $error("timer two did not step by one");

  timer_hold_a: assert property (!tick[0] |=> $stable(q.cnt[0]))
    else $error("timer one moved without an oscillator edge");

  port_edge_a: assert property ($rose(q.filt[0]) |-> q.req[timer_irq_pkg::SRC_PORT])
    else $error("port bit zero edge lost");

  pwm_req_a: assert property (pwm_period_end |=> q.req[timer_irq_pkg::SRC_PWM])
    else $error("pwm period end lost");

  irq_gate_a: assert property (##1 irq == |($past(d.req) & $past(d.mask)))
    else $error("interrupt does not follow request and mask");

  req_sticky_a: assert property (q.req[0] && !clr[0] |=> q.req[0])
    else $error("port request dropped without a clear");

  reload_write_a: assert property (wr_take && apb_req.paddr == timer_irq_pkg::OFS_RELOAD1
    |=> q.reload[0] == $past(apb_req.pwdata[7:0]))
    else $error("reload write not stored");

  pd_wake_a: assert property (power_down_indicator && wake |=> !power_down_indicator)
    else $error("pin change did not end power-down");

  sequence s_wrap2;
    tick[1] && q.cnt[1] == timer_irq_pkg::CNT_MAX;
  endsequence

  sequence s_wr_ctrl;
    wr_take && apb_req.paddr == timer_irq_pkg::OFS_CTRL;
  endsequence

  // timers: stepping, holding and wrapping of both counters
  timer2_wrap_a: assert property (s_wrap2 |=> q.cnt[1] == $past(q.reload[1]) && q.req[2])
    else $error("timer two did not reload and request");

  timer1_step_a: assert property (tick[0] && q.cnt[0] != timer_irq_pkg::CNT_MAX |=> q.cnt[0] == $past(q.cnt[0]) + 8'h01)
    else $error("timer one did not step by one");

  timer2_hold_a: assert property (!tick[1] |=> $stable(q.cnt[1]))
    else $error("timer two moved without an oscillator edge");

  enable_write_a: assert property (s_wr_ctrl |=> q.tmr_en == $past(apb_req.pwdata[1:0]))
    else $error("timer enables not stored");

  // register writes land on the pready edge
  reload2_write_a: assert property (wr_take && apb_req.paddr == timer_irq_pkg::OFS_RELOAD2
    |=> q.reload[1] == $past(apb_req.pwdata[7:0]))
    else $error("second reload write not stored");

  mask_write_a: assert property (wr_take && apb_req.paddr == timer_irq_pkg::OFS_MASK
    |=> q.mask == $past(apb_req.pwdata[4:0]))
    else $error("mask write not stored");

  out_write_a: assert property (wr_take && apb_req.paddr == timer_irq_pkg::OFS_OUT
    |=> q.out == $past(apb_req.pwdata[15:0]))
    else $error("pin output write not stored");

  mode_write_a: assert property (wr_take && apb_req.paddr == timer_irq_pkg::OFS_MODE
    |=> q.mode == $past(apb_req.pwdata))
    else $error("pin mode write not stored");

  // read data is taken from the registers as they stand in the first access cycle
  reload_read_a: assert property (rd_first && apb_req.paddr == timer_irq_pkg::OFS_RELOAD1
    |=> apb_rsp.prdata == {24'h00_0000, $past(q.reload[0])})
    else $error("reload read wrong");

  count_read_a: assert property (rd_first && apb_req.paddr == timer_irq_pkg::OFS_COUNT1
    |=> apb_rsp.prdata == {24'h00_0000, $past(q.cnt[0])})
    else $error("count read wrong");

  req_read_a: assert property (rd_first && apb_req.paddr == timer_irq_pkg::OFS_REQ
    |=> apb_rsp.prdata == {27'h000_0000, $past(q.req)})
    else $error("request read wrong");

  pins_read_a: assert property (rd_first && apb_req.paddr == timer_irq_pkg::OFS_PINS
    |=> apb_rsp.prdata == {16'h0000, $past(q.filt[15:0])})
    else $error("pin level read wrong");

  ctrl_read_a: assert property (rd_first && apb_req.paddr == timer_irq_pkg::OFS_CTRL
    |=> apb_rsp.prdata == {29'h0000_0000, $past(q.pd), $past(q.tmr_en)})
    else $error("control read wrong");

  apb_error_a: assert property (acc && !apb_rsp.pready && apb_req.paddr == 8'hFC |=> apb_rsp.pslverr)
    else $error("unmapped address not refused");

  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready stood longer than one cycle");

  // requests: every event sets, only a clear drops
  set_wins_a: assert property (1'b1 |=> ($past(ev) & ~q.req) == '0)
    else $error("event did not set its request");

  req_keep_a: assert property (1'b1 |=> ($past(q.req) & ~$past(clr) & ~q.req) == '0)
    else $error("request dropped without a clear");

  req_clear_a: assert property (wr_take && apb_req.paddr == timer_irq_pkg::OFS_CLR && apb_req.pwdata[0] && !ev[0]
    |=> !q.req[0])
    else $error("request clear ignored");

  reserved_req_a: assert property (reserved_event |=> q.req[timer_irq_pkg::SRC_RSV])
    else $error("reserved event lost");

  pwm_irq_a: assert property (pwm_period_end && q.mask[timer_irq_pkg::SRC_PWM] && !wr_take |=> irq)
    else $error("unmasked request gave no interrupt");

  // power-down is entered only by a control write and left only by a wake
  pd_entry_a: assert property (wr_take && apb_req.paddr == timer_irq_pkg::OFS_CTRL
    && apb_req.pwdata[timer_irq_pkg::CTRL_PD] && !wake |=> power_down_indicator)
    else $error("power-down not entered");

  pd_hold_a: assert property (!power_down_indicator && !wr_take |=> !power_down_indicator)
    else $error("power-down entered without a write");

  pd_stay_a: assert property (power_down_indicator && !wake |=> power_down_indicator)
    else $error("power-down left without a wake");

  // pad controls always match the stored mode and output data
  pad_oe_a: assert property (first_port_pins_ctl.oe[0] == (q.mode[1:0] == timer_irq_pkg::MODE_OUT))
    else $error("pad output enable does not follow mode");

  pad_pull_a: assert property (second_port_pins_ctl.weak_pu[0] == (q.mode[17:16] == timer_irq_pkg::MODE_WEAK))
    else $error("pad pull-up does not follow mode");

  pad_drv_a: assert property (first_port_pins_ctl.drv == q.out[7:0])
    else $error("pad drive does not follow output data");

endmodule : timer_irq_unit

`default_nettype wire

/* verif/pin_partner.sv */
// far side of the unit: both oscillators and the pads of the two ports
// assumes the bench steers the run enables and the external pin levels on sys_clk
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic                      sys_clk,
  input  wire logic                      fast_run,
  input  wire logic                      slow_run,
  input  wire logic [15:0]               ext_val,
  input  wire timer_irq_pkg::pin_drive_s p0_ctl,
  input  wire timer_irq_pkg::pin_drive_s p1_ctl,
  output logic                           fast_osc = 1'b0,
  output logic                           slow_osc = 1'b0,
  output logic [15:0]                    pin_lvl
);
  logic [15:0] oe;
  logic [15:0] drv;
  logic [7:0]  cyc = 8'h00;

  assign oe  = {p1_ctl.oe, p0_ctl.oe};
  assign drv = {p1_ctl.drv, p0_ctl.drv};
  // a pad the device drives shows its own level; otherwise the outside world wins
  assign pin_lvl = (oe & drv) | (~oe & ext_val);

  // oscillators stand still while stopped, so no stray ticks reach the timers
  always @(posedge sys_clk) begin
    cyc      <= cyc + 8'h01;
    fast_osc <= fast_run & cyc[2];
    slow_osc <= slow_run & cyc[3];
  end
endmodule : pin_partner
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench of the timer and interrupt unit
// assumes the unit answers each apb transfer with pready after one wait state
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
`define WR(a, d) xfer(1'b1, timer_irq_pkg::a, d);
`define RD(a) xfer(1'b0, timer_irq_pkg::a, 32'h0);
module tb_top;
  logic                      sys_clk  = 1'b0;
  logic                      srst     = 1'b1;
  timer_irq_pkg::apb_req_s   apb_req  = '0;
  timer_irq_pkg::apb_rsp_s   apb_rsp;
  timer_irq_pkg::pin_drive_s p0_ctl;
  timer_irq_pkg::pin_drive_s p1_ctl;
  logic                      fast_osc;
  logic                      slow_osc;
  logic                      fast_run = 1'b0;
  logic                      slow_run = 1'b0;
  logic                      pwm_end  = 1'b0;
  logic                      rsv_ev   = 1'b0;
  logic                      irq;
  logic                      pd;
  logic [15:0]               ext_val  = 16'h0000;
  logic [15:0]               pin_lvl;
  logic [31:0]               rd;
  logic                      er;
  int                        errors   = 0;
  int                        checked  = 0;
  int                        cycles   = 0;

  always #2 sys_clk = ~sys_clk;

  timer_irq_unit dut (.sys_clk(sys_clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .fast_osc_input(fast_osc), .slow_osc_input(slow_osc), .first_port_pins_lvl(pin_lvl[7:0]),
    .second_port_pins_lvl(pin_lvl[15:8]), .first_port_pins_ctl(p0_ctl), .second_port_pins_ctl(p1_ctl),
    .pwm_period_end(pwm_end), .reserved_event(rsv_ev), .irq(irq), .power_down_indicator(pd));

  pin_partner far_side (.sys_clk(sys_clk), .fast_run(fast_run), .slow_run(slow_run), .ext_val(ext_val),
    .p0_ctl(p0_ctl), .p1_ctl(p1_ctl), .fast_osc(fast_osc), .slow_osc(slow_osc), .pin_lvl(pin_lvl));

  // one edge of idle after each transfer keeps psel from being driven twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 16);
    if (apb_rsp.pready !== 1'b1) errors++;
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (irq !== 1'b1) errors++;
  endtask : wait_irq

  task automatic regs;
    `RD(OFS_CTRL)
    `CHK("ctrl", 32'h0000_0003, rd)
    `RD(OFS_MASK)
    `CHK("mask", 32'h0000_0000, rd)
    `WR(OFS_RELOAD1, 32'h0000_00A5)
    `WR(OFS_RELOAD2, 32'h0000_005A)
    `RD(OFS_RELOAD1)
    `CHK("reload1", 32'h0000_00A5, rd)
    `RD(OFS_RELOAD2)
    `CHK("reload2", 32'h0000_005A, rd)
    xfer(1'b0, 8'hFC, 32'h0);
    `CHK("unmapped err", 1'b1, er)
  endtask : regs

  task automatic timers;
    `WR(OFS_RELOAD1, 32'h0000_00FE)
    `WR(OFS_RELOAD2, 32'h0000_00FF)
    `WR(OFS_CLR, 32'h0000_001F)
    `WR(OFS_MASK, 32'h0000_0002)
    fast_run <= 1'b1;
    wait_irq(3000);
    `RD(OFS_REQ)
    `CHK("t1 overflow", 32'h0000_0002, rd)
    `RD(OFS_COUNT1)
    `CHK("t1 reload", 7'h7F, rd[7:1])
    fast_run <= 1'b0;
    `WR(OFS_MASK, 32'h0000_0004)
    `WR(OFS_CLR, 32'h0000_001F)
    slow_run <= 1'b1;
    wait_irq(5000);
    `RD(OFS_REQ)
    `CHK("t2 overflow", 32'h0000_0004, rd)
    slow_run <= 1'b0;
  endtask : timers

  task automatic events;
    `WR(OFS_MASK, 32'h0000_0000)
    `WR(OFS_CLR, 32'h0000_001F)
    pwm_end <= 1'b1;
    rsv_ev  <= 1'b1;
    @(posedge sys_clk);
    pwm_end <= 1'b0;
    rsv_ev  <= 1'b0;
    `RD(OFS_REQ)
    `CHK("pwm and reserved", 32'h0000_0018, rd)
    `CHK("irq masked", 1'b0, irq)
    `WR(OFS_MASK, 32'h0000_0010)
    @(posedge sys_clk);
    `CHK("irq unmasked", 1'b1, irq)
  endtask : events

  task automatic pins;
    `WR(OFS_CLR, 32'h0000_001F)
    ext_val[0] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `RD(OFS_REQ)
    `CHK("port edge", 32'h0000_0001, rd)
    `RD(OFS_PINS)
    `CHK("pin levels", 32'h0000_0001, rd)
    `WR(OFS_MODE, 32'h0003_0027)
    `WR(OFS_OUT, 32'h0000_0001)
    repeat (2) @(posedge sys_clk);
    `CHK("pad ctl", 32'h0101_0204, p0_ctl)
    `CHK("port1 pad ctl", 32'h0001_0000, p1_ctl)
    `WR(OFS_MODE, 32'h0000_0000)
  endtask : pins

  task automatic power;
    `WR(OFS_CTRL, 32'h0000_0007)
    repeat (2) @(posedge sys_clk);
    `CHK("pd entered", 1'b1, pd)
    ext_val[9] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK("pd woken", 1'b0, pd)
    `RD(OFS_RELOAD1)
    `CHK("reload kept", 32'h0000_00FE, rd)
  endtask : power

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // the slow timer needs about 4100 cycles to wrap, so this ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    regs;
    timers;
    events;
    pins;
    power;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
